// ### rtl/strap_pkg.sv
package strap_pkg;
  localparam int          DATA_W          = 16;
  localparam int          ADDR_LOW_W      = 3;
  localparam int          WIDE_CS_W       = 5;
  // Reset drive window and float window of the reset pin, in cycles
  localparam int          DRIVE_CYCLES    = 512;
  localparam int          FLOAT_CYCLES    = 10;
  localparam logic [9:0]  DRIVE_LAST      = 10'(DRIVE_CYCLES - 1);
  localparam logic [9:0]  FLOAT_LAST      = 10'(FLOAT_CYCLES - 1);
  // Strap bit positions on the data bus
  localparam int          BIT_BOOT_SIZE   = 0;
  localparam int          BIT_BUS_WIDTH   = 1;
  localparam int          BIT_CS_FUNC     = 2;
  localparam int          BIT_WIDE_LO     = 3;
  localparam int          BIT_PORT_E      = 8;
  localparam int          BIT_PORT_F      = 9;
  localparam int          BIT_GRANT_SEL   = 10;
  localparam int          BIT_TEST        = 11;
  localparam int          BIT_MODULE_LO   = 12;
  localparam int          BIT_MODULE_SEL  = 13;
  // Latched word after reset: all pull-up defaults
  localparam logic [15:0] STRAP_RESET     = 16'hffff;
  // Bus configuration codes
  localparam logic [1:0]  BUS_SINGLE      = 2'h0;
  localparam logic [1:0]  BUS_EXP8        = 2'h1;
  localparam logic [1:0]  BUS_EXP16       = 2'h2;

  typedef enum logic [2:0] {
    ST_DRIVE = 3'h1,
    ST_FLOAT = 3'h2,
    ST_RUN   = 3'h4
  } seq_state_t;
endpackage : strap_pkg

// ### rtl/cs_thermometer.sv
`timescale 1ns/1ps
// Low strap pin turns its select and all below into address lines
module cs_thermometer (
  input  wire logic [strap_pkg::WIDE_CS_W-1:0] i_strap,
  input  wire logic                            i_enable,
  output logic      [strap_pkg::WIDE_CS_W-1:0] o_is_addr
);
  always_comb begin
    for (int k = 0; k < strap_pkg::WIDE_CS_W; k++) begin
      o_is_addr[k] = 1'b0;
      for (int j = k; j < strap_pkg::WIDE_CS_W; j++) begin
        if (i_enable && !i_strap[j]) begin
          o_is_addr[k] = 1'b1;
        end
      end
    end
  end
endmodule : cs_thermometer

// ### rtl/reset_config_strap_decoder.sv
`timescale 1ns/1ps
// Operation
// [R1] Sample data, fault, clock, break pins in reset
// [R2] Weak pull-up on data pins during reset
// [R3] Board drives low straps and non-pulled pins
// [R4] Clock pin picks synth clock; break pin background
// [R5] Fault pin high expanded, low single-chip
// [R6] Data pin 1 picks 8 or 16 bits
// [R7] Extra options decoded only in 16-bit mode
// [R8] Data pin 8 low gives port E
// [R9] Data pin 9 low gives port F
// [R10] Single-chip: ports A, B, G, H
// [R11] 8-bit expanded: data low byte is port H
// [R12] 16-bit expanded: all pins are bus pins
// [R13] Low address floats in single-chip, drives expanded
// [R14] Data pin 0 sets boot select width
// [R15] Data pin 2 picks selects or request codes
// [R16] Data pins 7:3 thermometer selects to address
// [R17] Pins 10,1 low give emulation, 13 module
// [R18] Data pin 11 low gives test, 16-bit only
// [R19] Latch straps at end of float window
// [R20] Hold latched choices until next reset
module reset_config_strap_decoder (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // Reset request and reset pin
  input  wire logic        i_reset_request,
  input  wire logic        i_reset_pin,
  output logic             o_reset_pin_out,
  output logic             o_reset_pin_oe,
  output logic             o_in_reset,
  // Strap pins
  input  wire logic [15:0] i_data,
  input  wire logic        i_bus_fault_pin,
  input  wire logic        i_clock_source_select_pin,
  input  wire logic        i_debug_break_pin,
  output logic             o_data_pullup_en,
  // Basic options
  output logic             o_synth_clock,
  output logic             o_background_en,
  output logic [1:0]       o_bus_mode,
  output logic [3:0]       o_module_options,
  // Pin functions
  output logic             o_port_a_b_en,
  output logic             o_port_g_en,
  output logic             o_port_h_en,
  output logic             o_low_addr_drive,
  output logic             o_boot_rom_select_16,
  output logic             o_boot_rom_select_active,
  output logic             o_cs_0_3_5_en,
  output logic [4:0]       o_wide_addr_en,
  output logic             o_port_e_en,
  output logic             o_port_f_en,
  output logic             o_emulation_select_en,
  output logic             o_module_select_en,
  output logic             o_test_mode
);
  strap_pkg::seq_state_t state;
  strap_pkg::seq_state_t next_state;
  logic [9:0]            count;
  logic [9:0]            next_count;
  logic [15:0]           strap;
  logic [15:0]           next_strap;
  logic                  fault;
  logic                  next_fault;
  logic                  clk_sel;
  logic                  next_clk_sel;
  logic                  brk;
  logic                  next_brk;
  logic                  exp16;
  logic                  exp8;
  logic [4:0]            wide_addr;

  always_comb begin
    next_state   = state;
    next_count   = count;
    next_strap   = strap;
    next_fault   = fault;
    next_clk_sel = clk_sel;
    next_brk     = brk;
    case (state)
      strap_pkg::ST_DRIVE: begin
        if (i_reset_request) begin
          next_count = '0;
        end else if (count == strap_pkg::DRIVE_LAST) begin
          next_count = '0;
          next_state = strap_pkg::ST_FLOAT;
        end else begin
          next_count = count + 10'h001;
        end
      end
      strap_pkg::ST_FLOAT: begin
        if (count == strap_pkg::FLOAT_LAST) begin
          next_count   = '0;
          next_strap   = i_data;                                   // see [R1] see [R19]
          next_fault   = i_bus_fault_pin;                          // see [R1]
          next_clk_sel = i_clock_source_select_pin;                // see [R1]
          next_brk     = i_debug_break_pin;                        // see [R1]
          // Pin still held low by someone: another drive period
          next_state   = i_reset_pin ? strap_pkg::ST_RUN : strap_pkg::ST_DRIVE;
        end else begin
          next_count = count + 10'h001;
        end
      end
      strap_pkg::ST_RUN: begin
        // Choices frozen until a fresh request
        if (i_reset_request) begin                                 // see [R20]
          next_count = '0;
          next_state = strap_pkg::ST_DRIVE;
        end
      end
      default: begin
        next_count = '0;
        next_state = strap_pkg::ST_DRIVE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state   <= strap_pkg::ST_DRIVE;
      count   <= '0;
      strap   <= strap_pkg::STRAP_RESET;
      fault   <= 1'b1;
      clk_sel <= 1'b1;
      brk     <= 1'b1;
    end else begin
      state   <= next_state;
      count   <= next_count;
      strap   <= next_strap;
      fault   <= next_fault;
      clk_sel <= next_clk_sel;
      brk     <= next_brk;
    end
  end

  assign o_in_reset       = (state != strap_pkg::ST_RUN);
  assign o_reset_pin_out  = 1'b0;
  assign o_reset_pin_oe   = (state == strap_pkg::ST_DRIVE);
  assign o_data_pullup_en = o_in_reset;                            // see [R2]

  assign exp16 = fault && !strap[strap_pkg::BIT_BUS_WIDTH];         // see [R5] see [R6]
  assign exp8  = fault && strap[strap_pkg::BIT_BUS_WIDTH];          // see [R6]

  cs_thermometer u_thermo (
    .i_strap   (strap[strap_pkg::BIT_WIDE_LO +: strap_pkg::WIDE_CS_W]),
    .i_enable  (exp16),
    .o_is_addr (wide_addr)
  );

  always_comb begin
    o_synth_clock    = clk_sel;                                    // see [R4]
    o_background_en  = !brk;                                       // see [R4]
    o_bus_mode       = !fault ? strap_pkg::BUS_SINGLE :            // see [R5]
                       (exp8 ? strap_pkg::BUS_EXP8 : strap_pkg::BUS_EXP16);
    o_module_options = strap[strap_pkg::BIT_MODULE_LO +: 4];       // see [R1]
    o_port_a_b_en    = !fault;                                     // see [R10] see [R12]
    o_port_g_en      = !fault;                                     // see [R10] see [R11]
    o_port_h_en      = !exp16;                                     // see [R11] see [R12]
    o_low_addr_drive = fault;                                      // see [R13]
    // Fixed 8-bit boot in 8-bit mode, 16-bit in single-chip
    o_boot_rom_select_16 = exp16 ? strap[strap_pkg::BIT_BOOT_SIZE] : !exp8;  // see [R14] see [R7]
    o_boot_rom_select_active = !o_in_reset;                        // see [R14]
    o_cs_0_3_5_en    = !exp16 || strap[strap_pkg::BIT_CS_FUNC];    // see [R15] see [R7]
    o_wide_addr_en   = wide_addr;                                  // see [R16]
    o_port_e_en      = !fault || !strap[strap_pkg::BIT_PORT_E];    // see [R8]
    o_port_f_en      = !fault || !strap[strap_pkg::BIT_PORT_F];    // see [R9]
    o_emulation_select_en = exp16 && !strap[strap_pkg::BIT_GRANT_SEL];  // see [R17]
    o_module_select_en    = o_emulation_select_en &&
                            !strap[strap_pkg::BIT_MODULE_SEL];     // see [R17]
    o_test_mode      = exp16 && !strap[strap_pkg::BIT_TEST];       // see [R18] see [R7]
  end
endmodule : reset_config_strap_decoder

// ### test/strap_decoder_properties.sv
`timescale 1ns/1ps
module strap_decoder_checker (
  input wire logic       i_clock, i_rst_b, i_reset_request, o_reset_pin_oe, o_in_reset,
  input wire logic       o_data_pullup_en, o_port_a_b_en, o_port_g_en, o_port_h_en,
  input wire logic       o_low_addr_drive, o_boot_rom_select_active, o_cs_0_3_5_en,
  input wire logic       o_emulation_select_en, o_module_select_en, o_test_mode,
  input wire logic [1:0] o_bus_mode,
  input wire logic [4:0] o_wide_addr_en
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence float_ten;
    (!o_reset_pin_oe && o_in_reset) [*8] ##1 (!o_reset_pin_oe && o_in_reset) [*2];
  endsequence
  AST_FLOAT_TEN: assert property ($fell(o_reset_pin_oe) |-> float_ten ##1
    (o_reset_pin_oe || !o_in_reset)) else $error("float window length wrong");
  AST_HOLD: assert property (!o_in_reset && !$past(o_in_reset) |-> $stable({o_bus_mode,
    o_wide_addr_en, o_cs_0_3_5_en, o_test_mode})) else $error("latched choice moved");
  AST_RESTART: assert property (i_reset_request && !o_in_reset |=> o_reset_pin_oe)
    else $error("request did not restart drive");
  AST_PULLUP: assert property (o_data_pullup_en == o_in_reset) else $error("pull-up wrong");
  AST_BOOT: assert property (o_boot_rom_select_active != o_in_reset)
    else $error("boot select activity wrong");
  AST_SINGLE: assert property (o_bus_mode == strap_pkg::BUS_SINGLE |-> o_port_a_b_en
    && o_port_g_en && o_port_h_en && !o_low_addr_drive) else $error("single-chip pins wrong");
  AST_EXP8: assert property (o_bus_mode == strap_pkg::BUS_EXP8 |-> o_port_h_en
    && !o_port_g_en && !o_port_a_b_en && o_low_addr_drive) else $error("8-bit pins wrong");
  AST_EXP16: assert property (o_bus_mode == strap_pkg::BUS_EXP16 |-> !o_port_h_en
    && !o_port_g_en && !o_port_a_b_en && o_low_addr_drive) else $error("16-bit pins wrong");
  AST_FIXED: assert property (o_bus_mode != strap_pkg::BUS_EXP16 |-> o_cs_0_3_5_en
    && o_wide_addr_en == 5'h00 && !o_test_mode && !o_emulation_select_en
    && !o_module_select_en) else $error("narrow mode options not fixed");
endmodule : strap_decoder_checker

bind reset_config_strap_decoder strap_decoder_checker strap_decoder_checker_inst (.*);

// ### test/strap_board.sv
`timescale 1ns/1ps
module strap_board (
  input  wire logic        i_clock,
  input  wire logic        i_pullup_en,
  input  wire logic [15:0] i_low_mask,
  input  wire logic [2:0]  i_pins,
  output logic      [15:0] o_data,
  output logic      [2:0]  o_pins
);
  logic [15:0] traffic = 16'h0000;
  always @(posedge i_clock) traffic <= traffic + 16'h5a3d;
  // Straps only in reset; afterwards the lines carry traffic
  assign o_data = i_pullup_en ? ~i_low_mask : traffic;
  assign o_pins = i_pullup_en ? i_pins : ~i_pins;
endmodule : strap_board

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        i_clock = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_reset_request = 1'b0;
  logic        i_reset_pin = 1'b0;
  logic [15:0] low_mask = 16'h0000;
  logic [2:0]  pins = 3'h7;
  logic [15:0] i_data;
  logic [2:0]  pin_lv;
  logic        i_bus_fault_pin, i_clock_source_select_pin, i_debug_break_pin;
  logic        o_reset_pin_out, o_reset_pin_oe, o_in_reset, o_data_pullup_en, o_synth_clock;
  logic        o_background_en, o_port_a_b_en, o_port_g_en, o_port_h_en, o_low_addr_drive;
  logic        o_boot_rom_select_16, o_boot_rom_select_active, o_cs_0_3_5_en, o_port_e_en;
  logic        o_port_f_en, o_emulation_select_en, o_module_select_en, o_test_mode;
  logic [1:0]  o_bus_mode;
  logic [3:0]  o_module_options;
  logic [4:0]  o_wide_addr_en;
  int          err_count = 0;
  int          n_checks = 0;
  int          n;
  assign {i_bus_fault_pin, i_clock_source_select_pin, i_debug_break_pin} = pin_lv;
  always #4 i_clock = ~i_clock;
  initial #4905 i_reset_pin = 1'b1;
  reset_config_strap_decoder reset_config_strap_decoder_inst (.*);
  strap_board strap_board_inst (.i_clock(i_clock), .i_pullup_en(o_data_pullup_en),
    .i_low_mask(low_mask), .i_pins(pins), .o_data(i_data), .o_pins(pin_lv));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_run(output int cnt);
    cnt = 0;
    while (o_in_reset !== 1'b0) begin
      @(posedge i_clock);
      cnt++;
      if (cnt > 3000) begin
        err_count++;
        tally_and_finish();
      end
    end
    #1;
  endtask : wait_run

  task automatic strap(input logic [15:0] m, input logic [2:0] p);
    logic [15:0] d;
    logic [1:0]  md;
    logic        w;
    logic [4:0]  wd;
    @(posedge i_clock);
    #1 {low_mask, pins, i_reset_request} = {m, p, 1'b1};
    @(posedge i_clock);
    #1 i_reset_request = 1'b0;
    wait_run(n);
    d = ~m;
    md = !p[2] ? strap_pkg::BUS_SINGLE : (d[1] ? strap_pkg::BUS_EXP8 : strap_pkg::BUS_EXP16);
    w = (md == strap_pkg::BUS_EXP16);
    for (int k = 0; k < 5; k++) wd[k] = w & ((~d[7:3] >> k) != 5'h00);
    repeat (2) begin
      check("basic", {o_reset_pin_out, o_synth_clock, o_background_en, o_bus_mode},
        {1'b0, p[1], !p[0], md});
      check("ports", {o_port_a_b_en, o_port_g_en, o_port_h_en, o_low_addr_drive, o_port_e_en,
        o_port_f_en}, {md == 0, md == 0, !w, p[2], md == 0 || !d[8], md == 0 || !d[9]});
      check("selects", {o_boot_rom_select_active, o_boot_rom_select_16, o_cs_0_3_5_en,
        o_wide_addr_en}, {1'b1, w ? d[0] : md == 0, !(w && !d[2]), wd});
      check("options", {o_module_options, o_emulation_select_en, o_module_select_en, o_test_mode},
        {d[15:12], w && !d[10], w && !d[10] && !d[13], w && !d[11]});
      repeat (20) @(posedge i_clock);
      #1;
    end
  endtask : strap

  initial begin
    repeat (8) @(posedge i_clock);
    #1 i_rst_b = 1'b1;
    wait_run(n);
    check("retry", 16'(n > 1000), 16'h0001);
    strap(16'h0000, 3'h7);
    strap(16'hffff, 3'h0);
    strap(16'h0002, 3'h7);
    strap(16'h2f0f, 3'h5);
    strap(16'h0482, 3'h6);
    strap(16'h0022, 3'h7);
    strap(16'h0120, 3'h7);
    strap(16'h2402, 3'h7);
    tally_and_finish();
  end
endmodule : tb_top
